// ### verilog/ftl_pkg.sv
package ftl_pkg;

   // widths
   localparam int TEMP_W = 10;                    // 8.2 fixed point, quarter degrees
   localparam int DATA_W = 8;
   localparam int NUM_CH = 3;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_FAN1_FLOOR   = 8'h64;
   localparam logic [7:0] IDX_FAN2_FLOOR   = 8'h65;
   localparam logic [7:0] IDX_FAN3_FLOOR   = 8'h66;
   localparam logic [7:0] IDX_R1_START     = 8'h67;
   localparam logic [7:0] IDX_LOC_START    = 8'h68;
   localparam logic [7:0] IDX_R2_START     = 8'h69;
   localparam logic [7:0] IDX_R1_CRIT      = 8'h6a;
   localparam logic [7:0] IDX_LOC_CRIT     = 8'h6b;
   localparam logic [7:0] IDX_R2_CRIT      = 8'h6c;
   localparam logic [7:0] IDX_R1_LOC_HYST  = 8'h6d;
   localparam logic [7:0] IDX_R2_HYST      = 8'h6e;
   localparam logic [7:0] IDX_TREE_TEST    = 8'h6f;
   localparam logic [7:0] IDX_LOOP_CTRL    = 8'h60;
   localparam logic [7:0] IDX_LOOP_STATUS  = 8'h61;

   // reset values
   localparam logic [7:0] RST_FLOOR_DUTY   = 8'h80;
   localparam logic [7:0] RST_START_TEMP   = 8'h5a;
   localparam logic [7:0] RST_CRIT_LIMIT   = 8'h64;
   localparam logic [7:0] RST_R1_LOC_HYST  = 8'h44;
   localparam logic [7:0] RST_R2_HYST      = 8'h40;
   localparam logic [7:0] RST_TREE_TEST    = 8'h00;
   localparam logic [7:0] RST_LOOP_CTRL    = 8'h00;

   // field positions
   localparam int LOC_HYST_LSB   = 0;             // local_hyst_field [3:0]
   localparam int R1_HYST_LSB    = 4;             // remote1_hyst_field [7:4]
   localparam int R2_HYST_LSB    = 4;             // remote2_hyst_field [7:4]
   localparam int TREE_TEST_BIT  = 0;             // tree_test_bit
   localparam int CTRL_LOOP_BIT  = 0;             // automatic_fan_loop enable
   localparam int CTRL_LOCK_BIT  = 1;             // configuration lock, sticky
   localparam int CTRL_PINOE_BIT = 2;             // critical_temp_pin used as output
   localparam int STAT_OVR_LSB   = 0;             // [2:0] full-speed override per channel
   localparam int STAT_RUN_LSB   = 3;             // [5:3] fan running per channel
   localparam int STAT_PIN_BIT   = 6;             // critical_temp_pin level
   localparam int STAT_ANY_BIT   = 7;             // any override active

   // control values
   localparam logic [7:0] DUTY_FULL    = 8'hff;
   localparam logic [7:0] DUTY_OFF     = 8'h00;
   localparam logic [7:0] CRIT_DISABLE = 8'h80;
   localparam logic [7:0] RAMP_STEP    = 8'h08;   // duty counts per degree above start
   localparam logic [1:0] FRAC_QUARTER = 2'b01;

   // bus states
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_RDLOAD = 2'b01
   } ftl_bus_e;

endpackage

// ### verilog/ftl_regs.sv
`timescale 1ns/1ps

// Notes on behaviour
// - floor duty registers hold 8-bit PWM duty
// - floor duty writes ignored while loop active
// - above start temperature fan runs floor, ramps
// - lock makes start/critical/hysteresis/test read-only
// - any channel over critical forces all 100%
// - critical limit 0x80 disables override there
// - override holds until below limit minus hysteresis
// - critical pin driven low quarter degree over
// - critical limits reset to 0x64
// - hysteresis register: local [3:0], remote1 [7:4]
// - remote2 hysteresis register resets to 0x40
// - below start, floor duty until start minus hysteresis
// - tree test bit selects test mode
module ftl_regs (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // ahb-lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // measured temperatures, quarter degrees
   input  wire logic [ftl_pkg::TEMP_W-1:0]  tempRemote1,
   input  wire logic [ftl_pkg::TEMP_W-1:0]  tempLocal,
   input  wire logic [ftl_pkg::TEMP_W-1:0]  tempRemote2,
   // fan pwm duty
   output logic      [ftl_pkg::DATA_W-1:0]  fanDuty1,
   output logic      [ftl_pkg::DATA_W-1:0]  fanDuty2,
   output logic      [ftl_pkg::DATA_W-1:0]  fanDuty3,
   // critical temperature pin, open drain
   input  wire logic                        criticalTempPinIn,
   output logic                             criticalTempPinOut,
   output logic                             criticalTempPinOe,
   // test mode
   output logic                             treeTestMode
);
   import ftl_pkg::*;

   // register bank
   logic [7:0]   floorDuty [NUM_CH];
   logic [7:0]   startTemp [NUM_CH];
   logic [7:0]   critLimit [NUM_CH];
   logic [7:0]   r1LocHyst;
   logic [7:0]   r2Hyst;
   logic [7:0]   treeTest;
   logic         loopEnable;
   logic         cfgLock;
   logic         pinAsOutput;

   // channel state
   logic [NUM_CH-1:0] overrideOn;
   logic [NUM_CH-1:0] fanRunning;
   logic [9:0]        tempQ [NUM_CH];
   logic [7:0]        tempDeg [NUM_CH];
   logic [3:0]        hyst [NUM_CH];

   // bus state
   ftl_bus_e     busState;
   logic         wrPend;
   logic [7:0]   wrIdx;
   logic         wrValid;
   logic [7:0]   rdIdx;
   logic         rdValid;
   logic         addrPhase;
   logic         idxValid;
   logic [7:0]   idxNow;
   logic [7:0]   wrByte;
   logic [7:0]   next_rdByte;
   logic         critExceed;

   // saturating limit minus hysteresis
   function automatic logic [7:0] hystFloor(input logic [7:0] limit, input logic [3:0] h);
      logic [7:0] hWide;
      hWide = {4'h0, h};
      return (limit > hWide) ? (limit - hWide) : DUTY_OFF;
   endfunction

   // floor duty plus linear ramp above start, clipped to full
   function automatic logic [7:0] rampDuty(input logic [7:0] floorVal,
                                           input logic [7:0] temp,
                                           input logic [7:0] start);
      logic [15:0] above;
      logic [15:0] sum;
      above = (temp > start) ? {8'h00, temp - start} : 16'h0000;
      sum   = {8'h00, floorVal} + 16'(above * {8'h00, RAMP_STEP});
      return (sum > {8'h00, DUTY_FULL}) ? DUTY_FULL : sum[7:0];
   endfunction

   // write hit on a given index
   function automatic logic wrHit(input logic pend, input logic [7:0] idx,
                                  input logic [7:0] target);
      return pend && (idx == target);
   endfunction

   // channel order: 0 remote 1, 1 local, 2 remote 2
   assign tempQ[0] = tempRemote1;
   assign tempQ[1] = tempLocal;
   assign tempQ[2] = tempRemote2;

   // whole degrees, unsigned
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         tempDeg[c] = tempQ[c][9:2];
      end
   end

   // hysteresis fields per channel
   assign hyst[0] = r1LocHyst[R1_HYST_LSB +: 4];
   assign hyst[1] = r1LocHyst[LOC_HYST_LSB +: 4];
   assign hyst[2] = r2Hyst[R2_HYST_LSB +: 4];

   // address phase decode
   assign addrPhase = hsel && htrans[1] && hready;
   assign idxNow    = haddr[9:2];
   assign idxValid  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00) &&
                      ((idxNow >= IDX_FAN1_FLOOR && idxNow <= IDX_TREE_TEST) ||
                       idxNow == IDX_LOOP_CTRL || idxNow == IDX_LOOP_STATUS);
   assign wrByte    = hwdata[7:0];
   assign wrValid   = wrPend && (busState == BUS_IDLE);

   // bus sequencer: writes zero wait, reads one wait state
   always_ff @(posedge clk) begin
      if (rst) begin
         busState  <= BUS_IDLE;
         hreadyout <= 1'b1;
         wrPend    <= 1'b0;
         wrIdx     <= 8'h00;
         rdValid   <= 1'b0;
         rdIdx     <= 8'h00;
      end else begin
         case (busState)
            BUS_IDLE: begin
               wrPend <= addrPhase && hwrite && idxValid;
               if (addrPhase && hwrite) begin
                  wrIdx <= idxNow;
               end
               if (addrPhase && !hwrite) begin
                  rdIdx     <= idxNow;
                  rdValid   <= idxValid;
                  busState  <= BUS_RDLOAD;
                  hreadyout <= 1'b0;                    // stall data phase one cycle
               end
            end
            BUS_RDLOAD: begin
               wrPend    <= 1'b0;
               busState  <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
            default: begin
               busState  <= BUS_IDLE;
               hreadyout <= 1'b1;
               wrPend    <= 1'b0;
            end
         endcase
      end
   end

   // response is always okay
   always_ff @(posedge clk) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // read mux, unmapped reads zero
   always_comb begin
      next_rdByte = 8'h00;
      if (rdValid) begin
         case (rdIdx)
            IDX_FAN1_FLOOR:  next_rdByte = floorDuty[0];
            IDX_FAN2_FLOOR:  next_rdByte = floorDuty[1];
            IDX_FAN3_FLOOR:  next_rdByte = floorDuty[2];
            IDX_R1_START:    next_rdByte = startTemp[0];
            IDX_LOC_START:   next_rdByte = startTemp[1];
            IDX_R2_START:    next_rdByte = startTemp[2];
            IDX_R1_CRIT:     next_rdByte = critLimit[0];
            IDX_LOC_CRIT:    next_rdByte = critLimit[1];
            IDX_R2_CRIT:     next_rdByte = critLimit[2];
            IDX_R1_LOC_HYST: next_rdByte = r1LocHyst;
            IDX_R2_HYST:     next_rdByte = r2Hyst;
            IDX_TREE_TEST:   next_rdByte = treeTest;
            IDX_LOOP_CTRL: begin
               next_rdByte                 = 8'h00;
               next_rdByte[CTRL_LOOP_BIT]  = loopEnable;
               next_rdByte[CTRL_LOCK_BIT]  = cfgLock;
               next_rdByte[CTRL_PINOE_BIT] = pinAsOutput;
            end
            IDX_LOOP_STATUS: begin
               next_rdByte                    = 8'h00;
               next_rdByte[STAT_OVR_LSB +: 3] = overrideOn;
               next_rdByte[STAT_RUN_LSB +: 3] = fanRunning;
               next_rdByte[STAT_PIN_BIT]      = criticalTempPinIn;
               next_rdByte[STAT_ANY_BIT]      = |overrideOn;
            end
            default:         next_rdByte = 8'h00;
         endcase
      end
   end

   // read data loaded in the wait cycle, held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (busState == BUS_RDLOAD) begin
         hrdata <= {24'h00_0000, next_rdByte};
      end
   end

   // floor duty registers, frozen while the loop runs
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            floorDuty[c] <= RST_FLOOR_DUTY;
         end
      end else if (!loopEnable) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (wrHit(wrValid, wrIdx, IDX_FAN1_FLOOR + 8'(c))) begin
               floorDuty[c] <= wrByte;
            end
         end
      end
   end

   // start temperatures, frozen by lock
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            startTemp[c] <= RST_START_TEMP;
         end
      end else if (!cfgLock) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (wrHit(wrValid, wrIdx, IDX_R1_START + 8'(c))) begin
               startTemp[c] <= wrByte;
            end
         end
      end
   end

   // critical limits, frozen by lock
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            critLimit[c] <= RST_CRIT_LIMIT;
         end
      end else if (!cfgLock) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (wrHit(wrValid, wrIdx, IDX_R1_CRIT + 8'(c))) begin
               critLimit[c] <= wrByte;
            end
         end
      end
   end

   // hysteresis registers, frozen by lock
   always_ff @(posedge clk) begin
      if (rst) begin
         r1LocHyst <= RST_R1_LOC_HYST;
         r2Hyst    <= RST_R2_HYST;
      end else if (!cfgLock) begin
         if (wrHit(wrValid, wrIdx, IDX_R1_LOC_HYST)) begin
            r1LocHyst <= wrByte;
         end
         if (wrHit(wrValid, wrIdx, IDX_R2_HYST)) begin
            r2Hyst <= {wrByte[R2_HYST_LSB +: 4], 4'h0};
         end
      end
   end

   // test enable, only the low bit is stored
   always_ff @(posedge clk) begin
      if (rst) begin
         treeTest <= RST_TREE_TEST;
      end else if (!cfgLock && wrHit(wrValid, wrIdx, IDX_TREE_TEST)) begin
         treeTest <= {7'h00, wrByte[TREE_TEST_BIT]};
      end
   end

   // loop control, lock is sticky until reset
   always_ff @(posedge clk) begin
      if (rst) begin
         loopEnable  <= RST_LOOP_CTRL[CTRL_LOOP_BIT];
         cfgLock     <= RST_LOOP_CTRL[CTRL_LOCK_BIT];
         pinAsOutput <= RST_LOOP_CTRL[CTRL_PINOE_BIT];
      end else if (wrHit(wrValid, wrIdx, IDX_LOOP_CTRL)) begin
         loopEnable  <= wrByte[CTRL_LOOP_BIT];
         cfgLock     <= cfgLock | wrByte[CTRL_LOCK_BIT];
         pinAsOutput <= wrByte[CTRL_PINOE_BIT];
      end
   end

   // full-speed override per channel, with hysteresis release
   always_ff @(posedge clk) begin
      if (rst) begin
         overrideOn <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (critLimit[c] == CRIT_DISABLE) begin
               overrideOn[c] <= 1'b0;
            end else if (tempDeg[c] > critLimit[c]) begin
               overrideOn[c] <= 1'b1;
            end else if (tempDeg[c] < hystFloor(critLimit[c], hyst[c])) begin
               overrideOn[c] <= 1'b0;
            end
         end
      end
   end

   // fan running per channel, with hysteresis below start
   always_ff @(posedge clk) begin
      if (rst) begin
         fanRunning <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (tempDeg[c] > startTemp[c]) begin
               fanRunning[c] <= 1'b1;
            end else if (tempDeg[c] <= hystFloor(startTemp[c], hyst[c])) begin
               fanRunning[c] <= 1'b0;
            end
         end
      end
   end

   // duty drive: override, loop ramp, or manual floor
   always_ff @(posedge clk) begin
      if (rst) begin
         fanDuty1 <= DUTY_OFF;
         fanDuty2 <= DUTY_OFF;
         fanDuty3 <= DUTY_OFF;
      end else if (|overrideOn) begin
         fanDuty1 <= DUTY_FULL;
         fanDuty2 <= DUTY_FULL;
         fanDuty3 <= DUTY_FULL;
      end else if (loopEnable) begin
         fanDuty1 <= fanRunning[0] ? rampDuty(floorDuty[0], tempDeg[0], startTemp[0])
                                   : DUTY_OFF;
         fanDuty2 <= fanRunning[1] ? rampDuty(floorDuty[1], tempDeg[1], startTemp[1])
                                   : DUTY_OFF;
         fanDuty3 <= fanRunning[2] ? rampDuty(floorDuty[2], tempDeg[2], startTemp[2])
                                   : DUTY_OFF;
      end else begin
         fanDuty1 <= floorDuty[0];
         fanDuty2 <= floorDuty[1];
         fanDuty3 <= floorDuty[2];
      end
   end

   // quarter-degree overshoot on any enabled channel
   always_comb begin
      critExceed = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (critLimit[c] != CRIT_DISABLE &&
             tempQ[c] >= {critLimit[c], FRAC_QUARTER}) begin
            critExceed = 1'b1;
         end
      end
   end

   // critical pin pulled low while exceeded and configured as output
   always_ff @(posedge clk) begin
      if (rst) begin
         criticalTempPinOut <= 1'b0;
         criticalTempPinOe  <= 1'b0;
      end else begin
         criticalTempPinOut <= 1'b0;
         criticalTempPinOe  <= pinAsOutput && critExceed;
      end
   end

   // test mode output
   always_ff @(posedge clk) begin
      if (rst) begin
         treeTestMode <= 1'b0;
      end else begin
         treeTestMode <= treeTest[TREE_TEST_BIT];
      end
   end

endmodule

// ### dv/ftl_regs_checker.sv
`timescale 1ns/1ps
module ftl_regs_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // pin and test mode
   input wire logic        criticalTempPinOut,
   input wire logic        treeTestMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // transfers taken at this edge
   wire logic takeRd = hsel && htrans[1] && hready && !hwrite;
   wire logic takeWr = hsel && htrans[1] && hready && hwrite;
   read_one_wait_a: assert property (takeRd |=> !hreadyout ##1 hreadyout)
      else $error("read data phase without exactly one wait");
   write_no_wait_a: assert property (takeWr |=> hreadyout)
      else $error("write data phase stretched");
   ready_low_cause_a: assert property (!hreadyout |-> $past(takeRd))
      else $error("ready low outside a read");
   // read data only moves when a read completes
   rdata_change_cause_a: assert property ($changed(hrdata) |-> !$past(hreadyout) || $past(rst))
      else $error("read data moved without a read");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   pin_open_drain_a: assert property (criticalTempPinOut == 1'b0)
      else $error("pin drives high");
   rdata_byte_a: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   // test mode follows a written register only
   tree_mode_cause_a: assert property ($changed(treeTestMode) |->
      $past(takeWr, 2) || $past(takeWr, 3) || $past(rst))
      else $error("test mode changed without a write");
   cover property (takeRd);
   cover property (takeWr);
   cover property ($rose(treeTestMode));
endmodule

bind ftl_regs ftl_regs_checker ftl_regs_checker_i (
   .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .criticalTempPinOut(criticalTempPinOut), .treeTestMode(treeTestMode));

// ### dv/ftl_env_model.sv
`timescale 1ns/1ps
module ftl_env_model
   import ftl_pkg::*;
(
   // clock
   input  wire logic [0:0]        clk,
   // temperatures wanted by the bench
   input  wire logic [TEMP_W-1:0] setRemote1,
   input  wire logic [TEMP_W-1:0] setLocal,
   input  wire logic [TEMP_W-1:0] setRemote2,
   // device pulls the pin
   input  wire logic              pinOe,
   // sensor readings and pin level
   output logic      [TEMP_W-1:0] tempRemote1,
   output logic      [TEMP_W-1:0] tempLocal,
   output logic      [TEMP_W-1:0] tempRemote2,
   output wire logic              pinLevel
);
   // sensors hand over a fresh reading at each edge
   always_ff @(posedge clk) begin
      tempRemote1 <= setRemote1;
      tempLocal   <= setLocal;
      tempRemote2 <= setRemote2;
   end
   // pulled-up line, low only while the device pulls
   assign pinLevel = pinOe ? 1'b0 : 1'b1;
endmodule

// ### dv/tb_fan_thermal_limit_regs.sv
`timescale 1ns/1ps
module tb_fan_thermal_limit_regs;
   import ftl_pkg::*;
   logic              clk, rst, hsel, hwrite, loop, lock;
   logic [31:0]       haddr, hwdata, q;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [TEMP_W-1:0] sR1, sLo, sR2;
   logic [7:0]        m [12];
   logic [7:0]        e;
   wire logic [31:0]  hrdata;
   wire logic         hreadyout, hresp, pinOut, pinOe, pinLevel, treeTestMode;
   wire logic [TEMP_W-1:0] tR1, tLo, tR2;
   wire logic [DATA_W-1:0] duty1, duty2, duty3;
   int                fails, checks, i, h;
   ftl_regs ftl_regs_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tempRemote1(tR1), .tempLocal(tLo),
      .tempRemote2(tR2), .fanDuty1(duty1), .fanDuty2(duty2), .fanDuty3(duty3),
      .criticalTempPinIn(pinLevel), .criticalTempPinOut(pinOut),
      .criticalTempPinOe(pinOe), .treeTestMode(treeTestMode));
   ftl_env_model ftl_env_model_i (.clk(clk), .setRemote1(sR1), .setLocal(sLo),
      .setRemote2(sR2), .pinOe(pinOe), .tempRemote1(tR1), .tempLocal(tLo),
      .tempRemote2(tR2), .pinLevel(pinLevel));
   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // compare one value
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // wait for ready under a bound
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fails++;
         tally_and_finish();
      end
   endtask
   // one single transfer, address phase then data phase
   task automatic bus(logic [7:0] idx, logic wr, logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_ready();
      q = hrdata;
   endtask
   task automatic rchk(logic [7:0] idx, logic [7:0] exp);
      bus(idx, 1'b0, 8'h00);
      chk($sformatf("reg %h", idx), q, {24'h0, exp});
   endtask
   // write and keep the model in step
   task automatic wr(logic [7:0] idx, logic [7:0] d);
      int k;
      k = int'(idx) - 'h64;
      bus(idx, 1'b1, d);
      if (idx == IDX_LOOP_CTRL) begin
         loop = d[0];
         lock = lock | d[1];
      end else if (k < 3 ? !loop : !lock) begin
         m[k] = (k == 10) ? (d & 8'hf0) : (k == 11) ? (d & 8'h01) : d;
      end
   endtask
   // set temperatures, let them settle, compare the three duties
   task automatic fans(logic [TEMP_W-1:0] a, b, c, logic [7:0] e1, e2, e3);
      sR1 <= a;
      sLo <= b;
      sR2 <= c;
      repeat (4) @(posedge clk);
      chk("fanDuty1", duty1, e1);
      chk("fanDuty2", duty2, e2);
      chk("fanDuty3", duty3, e3);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = '0; sR1 = 10'd200; sLo = 10'd200; sR2 = 10'd200;
      fails = 0; checks = 0; loop = 1'b0; lock = 1'b0;
      m = '{8'h80, 8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00};
      void'($urandom(25));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values, then an unmapped place
      for (i = 0; i < 12; i++) rchk(8'(i + 'h64), m[i]);
      rchk(8'h70, 8'h00);
      // random floors and hysteresis of four or more, test bit set
      for (i = 0; i < 3; i++) wr(8'(i + 'h64), 8'($urandom));
      wr(IDX_R1_LOC_HYST, {4'(4 + $urandom % 12), 4'(4 + $urandom % 12)});
      wr(IDX_R2_HYST, {4'(4 + $urandom % 12), 4'($urandom)});
      wr(IDX_TREE_TEST, 8'h01);
      for (i = 0; i < 12; i++) rchk(8'(i + 'h64), m[i]);
      chk("treeTestMode", treeTestMode, 1'b1);
      wr(IDX_TREE_TEST, 8'h00);
      // register lands at the data-phase edge, the output one edge later
      repeat (2) @(posedge clk);
      chk("treeTestMode", treeTestMode, 1'b0);
      // manual mode follows floors, local over its default limit forces all
      fans(200, 200, 200, m[0], m[1], m[2]);
      fans(200, 101 * 4, 200, 8'hff, 8'hff, 8'hff);
      fans(200, 200, 200, m[0], m[1], m[2]);
      // remote1 override held down to limit minus hysteresis
      wr(IDX_R1_CRIT, 8'h50);
      h = int'(m[9][7:4]);
      fans(81 * 4, 200, 200, 8'hff, 8'hff, 8'hff);
      rchk(IDX_LOOP_STATUS, 8'hc1);
      fans(10'((80 - h) * 4), 200, 200, 8'hff, 8'hff, 8'hff);
      fans(10'((79 - h) * 4), 200, 200, m[0], m[1], m[2]);
      // pin pulled a quarter degree over the limit
      wr(IDX_LOOP_CTRL, 8'h04);
      fans(80 * 4 + 1, 200, 200, m[0], m[1], m[2]);
      chk("criticalTempPinOe", pinOe, 1'b1);
      rchk(IDX_LOOP_CTRL, 8'h04);
      rchk(IDX_LOOP_STATUS, 8'h00);
      fans(80 * 4, 200, 200, m[0], m[1], m[2]);
      chk("criticalTempPinOe", pinOe, 1'b0);
      // limit 0x80 switches the override off
      wr(IDX_R1_CRIT, 8'h80);
      fans(129 * 4, 200, 200, m[0], m[1], m[2]);
      // loop on: floors frozen, ramp above start, release at start minus hysteresis
      wr(IDX_LOOP_CTRL, 8'h01);
      wr(IDX_FAN1_FLOOR, 8'h20);
      rchk(IDX_FAN1_FLOOR, m[0]);
      wr(IDX_R1_START, 8'h40);
      e = (m[0] > 8'hf7) ? 8'hff : m[0] + 8'h08;
      fans(65 * 4, 200, 200, e, 8'h00, 8'h00);
      rchk(IDX_LOOP_STATUS, 8'h48);
      fans(63 * 4, 200, 200, m[0], 8'h00, 8'h00);
      fans(10'((64 - h) * 4), 200, 200, 8'h00, 8'h00, 8'h00);
      // lock freezes start, limit, hysteresis and test registers
      wr(IDX_LOOP_CTRL, 8'h02);
      for (i = 3; i < 12; i++) wr(8'(i + 'h64), (i == 11) ? 8'h01 : 8'h55);
      for (i = 0; i < 12; i++) rchk(8'(i + 'h64), m[i]);
      wr(IDX_LOOP_CTRL, 8'h00);
      rchk(IDX_LOOP_CTRL, 8'h02);
      tally_and_finish();
   end
endmodule
